/* sdo_port_regs.vh */
/*
 Register map, field positions, reset values and timing counts of the
 serial conversion-data output port.
 Assumes inclusion by bare name from the port's design files.
*/
`ifndef SDO_PORT_REGS_VH
`define SDO_PORT_REGS_VH

// ----------------------------------------
// Register byte offsets
// ----------------------------------------
`define SDO_ADDR_CTRL 8'h00
`define SDO_ADDR_CLKDIV 8'h04
`define SDO_ADDR_PERIOD 8'h08
`define SDO_ADDR_CHAIN 8'h0c
`define SDO_ADDR_STATUS 8'h10

// ----------------------------------------
// Control fields
// ----------------------------------------
`define SDO_CTRL_EN 0
`define SDO_CTRL_CLK_OUT 1
`define SDO_CTRL_GATED 2
`define SDO_CTRL_RC_MASTER 3
`define SDO_CTRL_FMT24 4
`define SDO_CTRL_HDR 5
`define SDO_CTRL_CRC_KEEP 6
`define SDO_CTRL_LANES_LO 7
`define SDO_CTRL_LANES_HI 8

// ----------------------------------------
// Reset values
// ----------------------------------------
`define SDO_RST_CTRL 9'h000
`define SDO_RST_CLKDIV 8'h01
`define SDO_RST_PERIOD 16'h0190
`define SDO_RST_CHAIN 8'h00

// ----------------------------------------
// Lane arrangements, CRC and timing
// ----------------------------------------
`define SDO_LANES_PAR 2'h0
`define SDO_LANES_TWO 2'h1
`define SDO_CRC_SEED 6'h25
`define SDO_CRC_POLY 6'h27
`define SDO_STROBE_W 16'h0008
`define SDO_PIN_CHAIN 8'h03

`endif

/* sdo_sync.v */
/*
 Two-flop synchroniser for a vector of independent level inputs.
 Assumes each bit is a slow level or a clock far below pclk.
*/
module sdo_sync #(
   parameter W = 1
) (
   // Clock, reset, enable
   input wire pclk,
   input wire presetn,
   input wire ce,
   // Levels
   input wire [W-1:0] d,
   output reg [W-1:0] q
);

   reg [W-1:0] meta_q;

   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         meta_q <= {W{1'b0}};
         q <= {W{1'b0}};
      end else if (ce) begin
         meta_q <= d;
         q <= meta_q;
      end
   end

endmodule

/* sdo_crc6.v */
/*
 Combinational CRC-6 over up to 26 message bits, MSB first.
 Assumes the message is left aligned in msg and nbits is at most 26.
*/
`include "sdo_port_regs.vh"

module sdo_crc6 (
   // Message
   input wire [5:0] seed,
   input wire [25:0] msg,
   input wire [4:0] nbits,
   // Result
   output reg [5:0] crc
);

   integer i;
   reg fb;

   // ----------------------------------------
   // Serial LFSR unrolled over the message
   // ----------------------------------------
   always @* begin
      crc = seed;
      fb = 1'b0;
      for (i = 0; i < 26; i = i + 1) begin
         if (i < nbits) begin
            fb = msg[25-i] ^ crc[5];
            crc = {crc[4:0], 1'b0} ^ (fb ? `SDO_CRC_POLY : 6'h00);
         end
      end
   end

endmodule

/* sdo_port.v */
/*
 Serial conversion-data output port: APB registers, data clock master or
 slave, frame strobe master or slave, headers with CRC, four lines.
 Assumes samples and status come from logic on pclk; link pins are async.
*/
// Local design decisions: the APB interface to the registers and the register offsets.
`include "sdo_port_regs.vh"

module sdo_port (
   // Clock, reset, enable
   input wire pclk,
   input wire presetn,
   input wire ce,
   // APB slave
   input wire psel,
   input wire penable,
   input wire pwrite,
   input wire [7:0] paddr,
   input wire [31:0] pwdata,
   output reg [31:0] prdata,
   output reg pready,
   output reg pslverr,
   // Converter core
   input wire [95:0] sample_data,
   input wire chip_error,
   input wire [3:0] filter_settled,
   input wire pll_locked,
   // Configuration pins
   input wire pin_control,
   input wire [1:0] clock_rate_straps,
   // Data clock pin
   input wire data_shift_clock_i,
   output reg data_shift_clock_o,
   output reg data_shift_clock_oe,
   // Rate strobe pin
   input wire rate_frame_strobe_i,
   output reg rate_frame_strobe_o,
   output reg rate_frame_strobe_oe,
   // Data lines
   input wire [3:0] serial_data_lines_i,
   output reg [3:0] serial_data_lines_o,
   output reg [3:0] serial_data_lines_oe
);

   // ----------------------------------------
   // Helpers
   // ----------------------------------------
   function [2:0] per_lane;
      input [1:0] lanes;
      begin
         if (lanes == `SDO_LANES_PAR)
            per_lane = 3'd1;
         else if (lanes == `SDO_LANES_TWO)
            per_lane = 3'd2;
         else
            per_lane = 3'd4;
      end
   endfunction

   function [1:0] chan_of;
      input [1:0] lanes;
      input [1:0] lane;
      input [1:0] widx;
      begin
         if (lanes == `SDO_LANES_PAR)
            chan_of = lane;
         else if (lanes == `SDO_LANES_TWO)
            chan_of = {lane[0], widx[0]};
         else
            chan_of = widx;
      end
   endfunction

   // ----------------------------------------
   // Registers and synchronised pins
   // ----------------------------------------
   reg [8:0] ctrl_q;
   reg [7:0] div_q;
   reg [15:0] period_q;
   reg [7:0] chain_q;
   reg [15:0] frames_q;
   reg [5:0] crc_q [0:3];
   reg [31:0] wbuf_q [0:3];
   wire [6:0] s_q;

   sdo_sync #(.W(7)) u_sync (
      .pclk(pclk),
      .presetn(presetn),
      .ce(ce),
      .d({clock_rate_straps, pin_control, serial_data_lines_i[3:2],
         rate_frame_strobe_i, data_shift_clock_i}),
      .q(s_q)
   );

   wire en = ctrl_q[`SDO_CTRL_EN];
   wire clk_out = ctrl_q[`SDO_CTRL_CLK_OUT];
   wire gated = ctrl_q[`SDO_CTRL_GATED];
   wire rc_master = ctrl_q[`SDO_CTRL_RC_MASTER];
   wire fmt24 = ctrl_q[`SDO_CTRL_FMT24];
   wire hdr_en = ctrl_q[`SDO_CTRL_HDR];
   wire [1:0] lanes = ctrl_q[`SDO_CTRL_LANES_HI:`SDO_CTRL_LANES_LO];
   wire pin = s_q[4];
   wire [1:0] straps = s_q[6:5];
   // Chaining of CRCs is a register-only option
   wire crc_keep = ctrl_q[`SDO_CTRL_CRC_KEEP] & ~pin;
   wire par = (lanes == `SDO_LANES_PAR);

   // ----------------------------------------
   // Frame geometry
   // ----------------------------------------
   wire [7:0] div_eff = pin ? (8'h01 << straps) : div_q;
   // Word plus optional header, always a whole number of bytes
   wire [5:0] wbits = (fmt24 ? 6'd24 : 6'd16) + (hdr_en ? 6'd8 : 6'd0);
   wire [2:0] spl = per_lane(lanes);
   wire [7:0] own_bits = {2'b00, wbits} * {5'h00, spl};
   // Parallel output never carries cascaded devices
   wire [7:0] chain_eff = par ? 8'h00 : (pin ? `SDO_PIN_CHAIN : chain_q);
   wire [16:0] total_w = own_bits * ({1'b0, chain_eff} + 9'd1);
   wire [15:0] total = total_w[15:0];

   // ----------------------------------------
   // Header words and CRC per channel
   // ----------------------------------------
   wire [127:0] words;
   wire [23:0] crc_all;

   genvar c;
   generate
      for (c = 0; c < 4; c = c + 1) begin : g_ch
         wire [23:0] d = sample_data[c*24+23:c*24];
         wire [23:0] dw = fmt24 ? d : {d[23:8], 8'h00};
         wire st_err = chip_error;
         wire st_ok = filter_settled[c] & (rc_master | pll_locked);
         wire [5:0] seed = crc_keep ? crc_q[c] : `SDO_CRC_SEED;
         wire [5:0] crc;
         sdo_crc6 u_crc (
            .seed(seed),
            .msg({st_err, st_ok, dw}),
            .nbits(fmt24 ? 5'd26 : 5'd18),
            .crc(crc)
         );
         assign crc_all[c*6+5:c*6] = crc;
         // Header ahead of the word, both left aligned
         assign words[c*32+31:c*32] = hdr_en ? {st_err, st_ok, crc, dw} : {dw, 8'h00};
      end
   endgenerate

   // ----------------------------------------
   // Data clock: divider as master, edge finder as slave
   // ----------------------------------------
   reg [7:0] dcnt_q;
   reg data_shift_clock_q;
   reg sdclk_q;
   reg [15:0] left_q;
   reg [15:0] own_q;
   reg [4:0] bit_q;
   reg [1:0] widx_q;

   // Gated clock stops after the falling edge that ends the frame
   wire run = en & clk_out & (~gated | (left_q != 16'h0000) | data_shift_clock_q);
   wire wrap = ({8'h00, dcnt_q} + 16'h0001) >= {8'h00, div_eff};
   wire mrise = run & wrap & ~data_shift_clock_q;
   wire srise = s_q[0] & ~sdclk_q;
   wire shift_ev = en & (clk_out ? mrise : srise);

   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         dcnt_q <= 8'h00;
         data_shift_clock_q <= 1'b0;
         sdclk_q <= 1'b0;
      end else if (ce) begin
         sdclk_q <= s_q[0];
         if (!run) begin
            dcnt_q <= 8'h00;
            data_shift_clock_q <= 1'b0;
         end else if (wrap) begin
            dcnt_q <= 8'h00;
            data_shift_clock_q <= ~data_shift_clock_q;
         end else begin
            dcnt_q <= dcnt_q + 8'h01;
         end
      end
   end

   // ----------------------------------------
   // Rate strobe: generator as master, edge finder as slave
   // ----------------------------------------
   reg [15:0] pcnt_q;
   reg odr_q;
   reg stb_d_q;

   wire stb = rc_master ? odr_q : s_q[1];
   wire stb_rise = stb & ~stb_d_q;
   wire stb_fall = ~stb & stb_d_q;
   // Gated clock frames hang off the falling edge, free running off the rising
   wire frame_ev = en & (gated ? stb_fall : stb_rise);

   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pcnt_q <= 16'h0000;
         odr_q <= 1'b0;
         stb_d_q <= 1'b0;
      end else if (ce) begin
         stb_d_q <= stb;
         if (!(en & rc_master)) begin
            pcnt_q <= 16'h0000;
            odr_q <= 1'b0;
         end else begin
            if (pcnt_q + 16'h0001 >= period_q)
               pcnt_q <= 16'h0000;
            else
               pcnt_q <= pcnt_q + 16'h0001;
            odr_q <= (pcnt_q < `SDO_STROBE_W);
         end
      end
   end

   // ----------------------------------------
   // Frame load and shifter
   // ----------------------------------------
   integer i;

   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         left_q <= 16'h0000;
         own_q <= 16'h0000;
         bit_q <= 5'h00;
         widx_q <= 2'h0;
         frames_q <= 16'h0000;
         serial_data_lines_o <= 4'h0;
         for (i = 0; i < 4; i = i + 1) begin
            crc_q[i] <= 6'h00;
            wbuf_q[i] <= 32'h0000_0000;
         end
      end else if (ce) begin
         if (frame_ev) begin
            // A new strobe restarts the frame even if the last one ran short
            left_q <= total;
            own_q <= {8'h00, own_bits};
            bit_q <= 5'h00;
            widx_q <= 2'h0;
            frames_q <= frames_q + 16'h0001;
            for (i = 0; i < 4; i = i + 1) begin
               wbuf_q[i] <= words[i*32 +: 32];
               crc_q[i] <= crc_all[i*6 +: 6];
            end
         end else if (shift_ev && left_q != 16'h0000) begin
            left_q <= left_q - 16'h0001;
            for (i = 0; i < 4; i = i + 1) begin
               if (own_q != 16'h0000)
                  serial_data_lines_o[i] <= wbuf_q[chan_of(lanes, i[1:0], widx_q)][5'd31 - bit_q];
               else if (i < 2)
                  serial_data_lines_o[i] <= s_q[2 + i];
               else
                  serial_data_lines_o[i] <= 1'b0;
            end
            if (own_q != 16'h0000) begin
               own_q <= own_q - 16'h0001;
               if ({1'b0, bit_q} == wbits - 6'd1) begin
                  bit_q <= 5'h00;
                  widx_q <= widx_q + 2'h1;
               end else begin
                  bit_q <= bit_q + 5'h01;
               end
            end
         end
      end
   end

   // ----------------------------------------
   // Pin drivers
   // ----------------------------------------
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         data_shift_clock_o <= 1'b0;
         data_shift_clock_oe <= 1'b0;
         rate_frame_strobe_o <= 1'b0;
         rate_frame_strobe_oe <= 1'b0;
         serial_data_lines_oe <= 4'h0;
      end else if (ce) begin
         data_shift_clock_o <= run & (wrap ? ~data_shift_clock_q : data_shift_clock_q);
         data_shift_clock_oe <= en & clk_out;
         rate_frame_strobe_o <= odr_q;
         rate_frame_strobe_oe <= en & rc_master;
         // Serialized modes free lines two and three as cascade inputs
         if (!en)
            serial_data_lines_oe <= 4'h0;
         else if (par)
            serial_data_lines_oe <= 4'hf;
         else if (lanes == `SDO_LANES_TWO)
            serial_data_lines_oe <= 4'h3;
         else
            serial_data_lines_oe <= 4'h1;
      end
   end

   // ----------------------------------------
   // APB slave: one access phase, no waits
   // ----------------------------------------
   wire setup = psel & ~penable;
   wire wr = psel & penable & pready & pwrite;
   reg [31:0] rd_d;
   reg hit_d;

   always @* begin
      hit_d = 1'b1;
      rd_d = 32'h0000_0000;
      case (paddr)
         `SDO_ADDR_CTRL: rd_d = {23'h000000, ctrl_q};
         `SDO_ADDR_CLKDIV: rd_d = {24'h000000, div_q};
         `SDO_ADDR_PERIOD: rd_d = {16'h0000, period_q};
         `SDO_ADDR_CHAIN: rd_d = {24'h000000, chain_q};
         `SDO_ADDR_STATUS: rd_d = {frames_q, 2'h0, crc_q[0], 6'h00, pin, left_q != 16'h0000};
         default: hit_d = 1'b0;
      endcase
   end

   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctrl_q <= `SDO_RST_CTRL;
         div_q <= `SDO_RST_CLKDIV;
         period_q <= `SDO_RST_PERIOD;
         chain_q <= `SDO_RST_CHAIN;
         prdata <= 32'h0000_0000;
         pready <= 1'b0;
         pslverr <= 1'b0;
      end else if (ce) begin
         pready <= setup;
         // Error flag stands with pready only, never beyond
         pslverr <= setup & ~hit_d;
         if (setup) begin
            prdata <= pwrite ? 32'h0000_0000 : rd_d;
         end
         if (wr) begin
            case (paddr)
               `SDO_ADDR_CTRL: ctrl_q <= pwdata[8:0];
               `SDO_ADDR_CLKDIV: div_q <= (pwdata[7:0] == 8'h00) ? 8'h01 : pwdata[7:0];
               `SDO_ADDR_PERIOD: period_q <= pwdata[15:0];
               `SDO_ADDR_CHAIN: chain_q <= pwdata[7:0];
               default: ctrl_q <= ctrl_q;
            endcase
         end
      end
   end

endmodule

/* sdo_port_chk.sv */
/*
 Port checks of the data output port.
 Assumes bind to sdo_port; ce drops only away from strobe pulses.
*/
module sdo_port_chk (
   // Clock, reset, enable
   input wire pclk,
   input wire presetn,
   input wire ce,
   // APB
   input wire psel,
   input wire penable,
   input wire pready,
   input wire pslverr,
   input wire [7:0] paddr,
   input wire [31:0] prdata,
   // Link pins
   input wire data_shift_clock_o,
   input wire data_shift_clock_oe,
   input wire rate_frame_strobe_o,
   input wire rate_frame_strobe_oe,
   input wire [3:0] serial_data_lines_o,
   input wire [3:0] serial_data_lines_oe
);
   // ---
   // Assertions
   // ---
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   a_ready_follows: assert property (psel && !penable && ce |=> pready)
      else $error("no pready after setup");
   a_ready_pulse: assert property (pready && ce |=> !pready)
      else $error("pready too long");
   a_unmapped_err: assert property (pready && paddr > 8'h10 |-> pslverr && prdata == 32'h0)
      else $error("unmapped not refused");
   a_mapped_ok: assert property (pready && paddr <= 8'h10 && paddr[1:0] == 2'h0 |-> !pslverr)
      else $error("mapped refused");
   a_err_ready: assert property (pslverr |-> pready)
      else $error("pslverr alone");
   a_reset_quiet: assert property (!$past(presetn) |-> !data_shift_clock_oe && serial_data_lines_oe == 4'h0)
      else $error("driving after reset");
   a_strobe_width: assert property ($rose(rate_frame_strobe_o) && rate_frame_strobe_oe |->
      rate_frame_strobe_o [*8] ##1 !rate_frame_strobe_o) else $error("strobe width");
   // Launch only with the clock rise, so the host can take bits on the fall
   a_bits_on_rise: assert property (data_shift_clock_oe && $stable(serial_data_lines_oe) &&
      !$stable(serial_data_lines_o & serial_data_lines_oe) |-> $rose(data_shift_clock_o)) else $error("bit off rise");
   a_clock_drive: assert property (data_shift_clock_o |-> data_shift_clock_oe)
      else $error("clock undriven");

   c_frame: cover property ($fell(rate_frame_strobe_o));
   c_refused: cover property (pready && pslverr);
   c_slave_bits: cover property (!data_shift_clock_oe && $changed(serial_data_lines_o));
endmodule

/* sdo_port_host.sv */
/*
 Far-side host: takes the lines; as master drives strobe and clock.
 Assumes the bench resolves each pin from the port's enables alone.
*/
module sdo_host (
   // Wires
   input wire data_shift_clock,
   input wire [3:0] dl,
   input wire slave,
   // Host drives
   output logic clk_o,
   output logic strb_o,
   output logic [1:0] casc
);
   timeunit 1ns;
   timeprecision 100ps;
   logic [31:0] cap [4];
   int nrise;
   initial begin
      clk_o = 0;
      strb_o = 0;
      casc = 2'h2;
   end
   task automatic clr();
      for (int l = 0; l < 4; l++) cap[l] = 0;
      nrise = 0;
   endtask
   task automatic grab();
      for (int l = 0; l < 4; l++) cap[l] = {cap[l][30:0], dl[l]};
   endtask
   // Cascade inputs keep changing so a stale value never passes
   always @(negedge data_shift_clock) begin
      casc <= ~casc;
      if (!slave) grab();
   end
   always @(posedge data_shift_clock) if (!slave) nrise++;
   // Clock idles low; bit i is read at rise i+1, before resync relaunch
   task automatic frame(input int n);
      #7 strb_o = 1;
      #400 strb_o = 0;
      #400;
      for (int i = 0; i <= n; i++) begin
         if (i > 0) grab();
         clk_o = 1;
         #100 clk_o = 0;
         #100;
      end
   endtask
endmodule

/* sdo_port_tb.sv */
/*
 Bench: registers, master and slave frames, CRC, lanes, cascade.
 Assumes the port, its header and the host model.
*/
`include "sdo_port_regs.vh"
`define CHK(nm, ex, got) begin checks_done++; if ((got) !== (ex)) begin miscompares++; $display("BAD %s exp %0h got %0h", nm, ex, got); end end

module sdo_port_tb;
   timeunit 1ns;
   timeprecision 100ps;
   // ---
   // Signals
   // ---
   logic pclk = 0, presetn = 0, ce = 1, psel = 0, penable = 0, pwrite = 0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0;
   logic [95:0] sample_data = 96'hc3a5e1_5a3c96_0f1e2d_f0e1d2;
   logic chip_error = 1, pll_locked = 0, pin_control = 0, slv = 0, ps = 0;
   logic [3:0] filter_settled = 4'hb;
   logic [1:0] clock_rate_straps = 2'h0;
   wire [31:0] prdata;
   wire pready, pslverr, data_shift_clock_i, data_shift_clock_o, data_shift_clock_oe, h_clk, h_strb;
   wire rate_frame_strobe_i, rate_frame_strobe_o, rate_frame_strobe_oe;
   wire [3:0] serial_data_lines_i, serial_data_lines_o, serial_data_lines_oe;
   wire [1:0] casc;
   logic [5:0] sd [4], lc [4];
   int miscompares = 0, checks_done = 0, cyc = 0;

   assign data_shift_clock_i = data_shift_clock_oe ? data_shift_clock_o : h_clk;
   assign rate_frame_strobe_i = rate_frame_strobe_oe ? rate_frame_strobe_o : h_strb;
   assign serial_data_lines_i = serial_data_lines_oe & serial_data_lines_o | ~serial_data_lines_oe & {casc, 2'h0};

   sdo_port dut (.pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .sample_data(sample_data), .chip_error(chip_error), .filter_settled(filter_settled),
      .pll_locked(pll_locked), .pin_control(pin_control), .clock_rate_straps(clock_rate_straps),
      .data_shift_clock_i(data_shift_clock_i), .data_shift_clock_o(data_shift_clock_o),
      .data_shift_clock_oe(data_shift_clock_oe), .rate_frame_strobe_i(rate_frame_strobe_i),
      .rate_frame_strobe_o(rate_frame_strobe_o), .rate_frame_strobe_oe(rate_frame_strobe_oe),
      .serial_data_lines_i(serial_data_lines_i), .serial_data_lines_o(serial_data_lines_o),
      .serial_data_lines_oe(serial_data_lines_oe));
   sdo_host host (.data_shift_clock(data_shift_clock_i), .dl(serial_data_lines_i), .slave(slv), .clk_o(h_clk),
      .strb_o(h_strb), .casc(casc));

   always #12.5 pclk = ~pclk;
   always @(posedge pclk) begin
      ps <= rate_frame_strobe_i;
      cyc++;
      if (cyc == 30000) begin
         miscompares++;
         wrap_up();
      end
   end

   task automatic wrap_up();
      $display("checks %0d mismatches %0d", checks_done, miscompares);
      if (miscompares == 0 && checks_done > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask

   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r,
                      output logic e);
      // One idle edge keeps the last release and the next setup apart
      @(posedge pclk);
      psel <= 1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1;
      do begin
         @(posedge pclk);
      end while (pready !== 1'b1);
      r = prdata;
      e = pslverr;
      psel <= 0;
      penable <= 0;
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] r;
      logic e;
      apb(1, a, d, r, e);
   endtask

   task automatic wait_fall();
      int n = 0;
      do begin
         @(posedge pclk);
         n++;
      end while (!(ps && !rate_frame_strobe_i) && n < 2000);
   endtask

   function automatic logic [31:0] word(input int ch, input bit f24, hdr, sl, input logic [5:0] s,
                                        output logic [5:0] c);
      logic st, fb;
      logic [23:0] d;
      logic [25:0] m;
      st = filter_settled[ch] & (!sl | pll_locked);
      d = sample_data[ch*24 +: 24];
      m = f24 ? {chip_error, st, d} : {chip_error, st, d[23:8], 8'h00};
      c = s;
      for (int i = 0; i < (f24 ? 26 : 18); i++) begin
         fb = c[5] ^ m[25 - i];
         c = {c[4:0], 1'b0} ^ (fb ? 6'h27 : 6'h00);
      end
      word = f24 ? d : d[23:8];
      if (hdr) word = f24 ? {chip_error, st, c, d} : {chip_error, st, c, d[23:8]};
   endfunction

   // ---
   // Scenarios
   // ---
   task automatic t_regs();
      logic [31:0] r;
      logic e;
      apb(0, `SDO_ADDR_PERIOD, 0, r, e);
      `CHK("period", 32'h190, r)
      apb(1, `SDO_ADDR_CLKDIV, 0, r, e);
      apb(0, `SDO_ADDR_CLKDIV, 0, r, e);
      `CHK("clkdiv", 32'h1, r)
      apb(0, 8'h14, 0, r, e);
      `CHK("unmapped", 33'h100000000, ({e, r}))
      apb(0, `SDO_ADDR_CTRL, 0, r, e);
      `CHK("ctrl", 32'h0, r)
   endtask

   task automatic t_frame(input bit f24, hdr, two, keep, sl);
      logic [63:0] e;
      logic [5:0] c;
      int k, nb;
      nb = (f24 ? 24 : 16) + (hdr ? 8 : 0);
      host.clr();
      if (sl) host.frame(nb);
      else begin
         wait_fall();
         host.clr();
         repeat (150) @(posedge pclk);
         `CHK("rises", (two ? 2 : 1) * nb, host.nrise)
      end
      `CHK("pin dirs", ({2{!sl}}), ({data_shift_clock_oe, rate_frame_strobe_oe}))
      `CHK("line dirs", (two ? 4'h3 : 4'hf), serial_data_lines_oe)
      if (sl) `CHK("settled", 1'b0, host.cap[0][22])
      for (int l = 0; l < 4; l++) begin
         e = 0;
         k = 0;
         for (int ch = 0; ch < 4; ch++)
            if (two ? ch / 2 == l : ch == l) begin
               e = (e << nb) | word(ch, f24, hdr, sl, sd[ch], c);
               lc[ch] = c;
               k += nb;
            end
         if (k > 0) `CHK("lane bits", e, host.cap[l] & ((64'h1 << k) - 1))
      end
      if (keep) sd = lc;
   endtask

   task automatic t_count(input int n, w);
      wait_fall();
      host.clr();
      repeat (w) @(posedge pclk);
      `CHK("rises", n, host.nrise)
   endtask

   task automatic t_pin();
      logic [31:0] r;
      logic e;
      realtime t0;
      pin_control <= 1;
      clock_rate_straps <= 2'h1;
      wr(`SDO_ADDR_PERIOD, 32'h500);
      wr(`SDO_ADDR_CTRL, 32'h0f);
      t_count(16, 330);
      wait_fall();
      @(posedge data_shift_clock_i);
      t0 = $realtime;
      @(negedge data_shift_clock_i);
      `CHK("half period", 2, int'(($realtime - t0) / 25.0))
      wr(`SDO_ADDR_CTRL, 32'h10f);
      t_count(256, 1100);
      apb(0, `SDO_ADDR_STATUS, 0, r, e);
      `CHK("pin flag", 2'h2, r[1:0])
      pin_control <= 0;
      clock_rate_straps <= 2'h0;
      wr(`SDO_ADDR_PERIOD, 32'h190);
   endtask

   task automatic t_free();
      int n;
      wr(`SDO_ADDR_CTRL, 32'h0b);
      @(posedge rate_frame_strobe_i);
      @(posedge pclk);
      host.clr();
      repeat (150) @(posedge pclk);
      `CHK("free rises", 75, host.nrise)
      ce <= 0;
      @(posedge pclk);
      n = host.nrise;
      repeat (20) @(posedge pclk);
      `CHK("frozen", n, host.nrise)
      ce <= 1;
   endtask

   initial begin
      repeat (4) @(posedge pclk);
      presetn <= 1;
      @(posedge pclk);
      t_regs();
      sd = '{4{6'h25}};
      wr(`SDO_ADDR_CTRL, 32'h0f);
      t_frame(0, 0, 0, 0, 0);
      wr(`SDO_ADDR_CTRL, 32'h8f);
      t_frame(0, 0, 1, 0, 0);
      wr(`SDO_ADDR_CTRL, 32'h3f);
      t_frame(1, 1, 0, 0, 0);
      t_frame(1, 1, 0, 0, 0);
      sd = lc;
      wr(`SDO_ADDR_CTRL, 32'h7f);
      t_frame(1, 1, 0, 1, 0);
      t_frame(1, 1, 0, 1, 0);
      wr(`SDO_ADDR_CHAIN, 32'h1);
      t_count(32, 330);
      wr(`SDO_ADDR_CTRL, 32'h10f);
      t_count(128, 330);
      wr(`SDO_ADDR_CHAIN, 32'h0);
      t_pin();
      t_free();
      sd = '{4{6'h25}};
      chip_error <= 0;
      slv <= 1;
      wr(`SDO_ADDR_CTRL, 32'h25);
      repeat (20) @(posedge pclk);
      t_frame(0, 1, 0, 0, 1);
      wrap_up();
   end
endmodule

bind sdo_port sdo_port_chk chk (.pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel), .penable(penable),
   .pready(pready), .pslverr(pslverr), .paddr(paddr), .prdata(prdata), .data_shift_clock_o(data_shift_clock_o),
   .data_shift_clock_oe(data_shift_clock_oe), .rate_frame_strobe_o(rate_frame_strobe_o),
   .rate_frame_strobe_oe(rate_frame_strobe_oe), .serial_data_lines_o(serial_data_lines_o),
   .serial_data_lines_oe(serial_data_lines_oe));
